// ---- shared/fasb_consts.vh ----
// Offsets, field positions, reset values and timing counts of the alert bank.
`ifndef FASB_CONSTS_VH
`define FASB_CONSTS_VH

`define FASB_ADDR_SAFETY_ALERT_ONE 8'h03
`define FASB_ADDR_CELL_ALERT_SUMMARY 8'h04
`define FASB_ADDR_OVERVOLTAGE_ALERTS 8'h05

`define FASB_RST_SAFETY_ALERT_ONE 16'h0000
`define FASB_RST_CELL_ALERT_SUMMARY 16'h0000
`define FASB_RST_OVERVOLTAGE_ALERTS 16'h0000

`define FASB_BIT_OSC_PRIMARY 15
`define FASB_BIT_OSC_REDUNDANT 14
`define FASB_BIT_UPPER_SE 12
`define FASB_BIT_LOWER_SE 11
`define FASB_BIT_UPPER_SE_COPY 10
`define FASB_BIT_LOWER_SE_COPY 9
`define FASB_BIT_LDO3_UV 8
`define FASB_BIT_LDO2_UV 7
`define FASB_BIT_GND2_OPEN 6
`define FASB_BIT_BAL_SW 5
`define FASB_BIT_DIE_OT 4
`define FASB_BIT_HV_UV 3
`define FASB_BIT_GND3_OPEN 2
`define FASB_BIT_LDO1_UV 1
`define FASB_BIT_GND1_OPEN 0
`define FASB_BIT_AUX1 13
`define FASB_BIT_AUX0 12

`define FASB_CLK_PERIOD_NS 20
`define FASB_OSC_UPDATE_NS 61035
`define FASB_OSC_UPDATE_CYC (`FASB_OSC_UPDATE_NS / `FASB_CLK_PERIOD_NS)

`endif

// ---- design/fasb_bank.v ----
// Fault and alert status bank: latched safety alerts, cell and aux summaries.
`timescale 1ns/1ps
`include "fasb_consts.vh"

module fasb_bank #(
	parameter NCELL = 12,
	parameter OSC_UPDATE_CYC = `FASB_OSC_UPDATE_CYC
) (
	// Clock and reset.
	input wire clk,
	input wire arst_n,
	// Register access port.
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_wdata,
	output reg [15:0] reg_rdata,
	output reg reg_rvalid,
	// Power-on alert held in the main status register.
	input wire power_on_alert,
	// Analog and communication fault sources.
	input wire osc_freq_err,
	input wire upper_rx_single_ended,
	input wire lower_rx_single_ended,
	input wire [2:0] ldo_undervolt,
	input wire [2:0] gnd_open,
	input wire hv_supply_undervolt,
	input wire die_overtemp,
	input wire diag_settle_short,
	input wire [NCELL-1:0] balance_switch_fault,
	// Acquisition results.
	input wire acq_done,
	input wire [NCELL-1:0] cell_over_cmp,
	input wire [NCELL-1:0] overvolt_alert_enable,
	input wire [NCELL-1:0] cell_undervolt,
	input wire [1:0] aux_cold_cmp,
	input wire [1:0] aux_hot,
	// Summaries for the main status register.
	output reg safety_alert_any,
	output reg overvolt_any
);

	reg rst_meta;
	reg rst_sync;
	reg [NCELL-1:0] cell_overvolt;
	reg [1:0] aux_cold;
	reg [NCELL-1:0] cell_alert;
	reg [1:0] aux_alert;
	reg [15:0] osc_cnt;
	reg osc_tick;
	reg bal_flag;
	reg [11:0] ov_cells;
	reg [11:0] sum_cells;
	reg [15:0] rd_mux;
	wire rst_n;
	wire wr_safety;
	wire gate_ok;
	wire osc_set;
	wire osc_fault_primary;
	wire osc_fault_redundant;
	wire se_upper;
	wire se_lower;
	wire upper_rx_single_ended_copy;
	wire lower_rx_single_ended_copy;
	wire ldo3_undervolt;
	wire ldo2_undervolt;
	wire ldo1_undervolt;
	wire gnd1_open;
	wire gnd2_open;
	wire gnd3_open;
	wire overtemp_alert;
	wire hv_alert;
	wire [15:0] safety_alert_one;
	wire [15:0] ov_word;
	wire [15:0] cell_word;

	// Reset release through two flip-flops.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end
	assign rst_n = rst_sync;

	// Enable pulse at the rate of two slow-oscillator cycles.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_cnt <= 16'h0000;
			osc_tick <= 1'b0;
		end else if (osc_cnt == OSC_UPDATE_CYC[15:0] - 16'h0001) begin
			osc_cnt <= 16'h0000;
			osc_tick <= 1'b1;
		end else begin
			osc_cnt <= osc_cnt + 16'h0001;
			osc_tick <= 1'b0;
		end
	end

	assign wr_safety = reg_wr && (reg_addr == `FASB_ADDR_SAFETY_ALERT_ONE);
	assign gate_ok = !power_on_alert;
	assign osc_set = osc_tick && osc_freq_err;

	// Latched alerts: a zero written clears, a one written keeps the bit.
	fasb_alert_latch osc_primary_i (
		.clk(clk),
		.rst_n(rst_n),
		.set(osc_set),
		.wr_en(wr_safety),
		.wdata(reg_wdata[`FASB_BIT_OSC_PRIMARY]),
		.q(osc_fault_primary)
	);

	fasb_alert_latch osc_redundant_i (
		.clk(clk),
		.rst_n(rst_n),
		.set(osc_set),
		.wr_en(wr_safety),
		.wdata(reg_wdata[`FASB_BIT_OSC_REDUNDANT]),
		.q(osc_fault_redundant)
	);

	fasb_alert_latch ldo3_i (
		.clk(clk),
		.rst_n(rst_n),
		.set(gate_ok && ldo_undervolt[2]),
		.wr_en(wr_safety),
		.wdata(reg_wdata[`FASB_BIT_LDO3_UV]),
		.q(ldo3_undervolt)
	);

	fasb_alert_latch ldo2_i (
		.clk(clk),
		.rst_n(rst_n),
		.set(gate_ok && ldo_undervolt[1]),
		.wr_en(wr_safety),
		.wdata(reg_wdata[`FASB_BIT_LDO2_UV]),
		.q(ldo2_undervolt)
	);

	fasb_alert_latch gnd2_i (
		.clk(clk),
		.rst_n(rst_n),
		.set(gate_ok && gnd_open[1]),
		.wr_en(wr_safety),
		.wdata(reg_wdata[`FASB_BIT_GND2_OPEN]),
		.q(gnd2_open)
	);

	fasb_alert_latch overtemp_i (
		.clk(clk),
		.rst_n(rst_n),
		.set(die_overtemp || diag_settle_short),
		.wr_en(wr_safety),
		.wdata(reg_wdata[`FASB_BIT_DIE_OT]),
		.q(overtemp_alert)
	);

	fasb_alert_latch hv_i (
		.clk(clk),
		.rst_n(rst_n),
		.set(gate_ok && hv_supply_undervolt),
		.wr_en(wr_safety),
		.wdata(reg_wdata[`FASB_BIT_HV_UV]),
		.q(hv_alert)
	);

	fasb_alert_latch gnd3_i (
		.clk(clk),
		.rst_n(rst_n),
		.set(gate_ok && gnd_open[2]),
		.wr_en(wr_safety),
		.wdata(reg_wdata[`FASB_BIT_GND3_OPEN]),
		.q(gnd3_open)
	);

	fasb_alert_latch ldo1_i (
		.clk(clk),
		.rst_n(rst_n),
		.set(gate_ok && ldo_undervolt[0]),
		.wr_en(wr_safety),
		.wdata(reg_wdata[`FASB_BIT_LDO1_UV]),
		.q(ldo1_undervolt)
	);

	fasb_alert_latch gnd1_i (
		.clk(clk),
		.rst_n(rst_n),
		.set(gate_ok && gnd_open[0]),
		.wr_en(wr_safety),
		.wdata(reg_wdata[`FASB_BIT_GND1_OPEN]),
		.q(gnd1_open)
	);

	// Single-ended indications are read-only and hold until reset.
	fasb_alert_latch se_upper_i (
		.clk(clk),
		.rst_n(rst_n),
		.set(upper_rx_single_ended && gate_ok),
		.wr_en(1'b0),
		.wdata(1'b0),
		.q(se_upper)
	);

	fasb_alert_latch se_lower_i (
		.clk(clk),
		.rst_n(rst_n),
		.set(lower_rx_single_ended && gate_ok),
		.wr_en(1'b0),
		.wdata(1'b0),
		.q(se_lower)
	);

	fasb_alert_latch se_upper_copy_i (
		.clk(clk),
		.rst_n(rst_n),
		.set(upper_rx_single_ended),
		.wr_en(1'b0),
		.wdata(1'b0),
		.q(upper_rx_single_ended_copy)
	);

	fasb_alert_latch se_lower_copy_i (
		.clk(clk),
		.rst_n(rst_n),
		.set(lower_rx_single_ended),
		.wr_en(1'b0),
		.wdata(1'b0),
		.q(lower_rx_single_ended_copy)
	);

	// The balancing bit drops with the fault; a zero write cannot outlast it.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			bal_flag <= 1'b0;
		else
			bal_flag <= |balance_switch_fault;
	end

	assign safety_alert_one = {osc_fault_primary, osc_fault_redundant, 1'b0,
		se_upper, se_lower, upper_rx_single_ended_copy,
		lower_rx_single_ended_copy, ldo3_undervolt, ldo2_undervolt, gnd2_open,
		bal_flag, overtemp_alert, hv_alert, gnd3_open, ldo1_undervolt,
		gnd1_open};

	// Overvoltage and cold alerts are rebuilt at each acquisition.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cell_overvolt <= {NCELL{1'b0}};
			aux_cold <= 2'b00;
		end else if (acq_done) begin
			cell_overvolt <= cell_over_cmp & overvolt_alert_enable;
			aux_cold <= aux_cold_cmp;
		end
	end

	// Summary bits follow the alert words one cycle later.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cell_alert <= {NCELL{1'b0}};
			aux_alert <= 2'b00;
		end else begin
			cell_alert <= cell_overvolt | cell_undervolt;
			aux_alert <= aux_cold | aux_hot;
		end
	end

	// Cells sit at bits 11..0; a smaller build leaves the top cells zero.
	always @* begin
		ov_cells = 12'h000;
		sum_cells = 12'h000;
		ov_cells[NCELL-1:0] = cell_overvolt;
		sum_cells[NCELL-1:0] = cell_alert;
	end

	assign ov_word = {2'b00, aux_cold, ov_cells};
	assign cell_word = {2'b00, aux_alert, sum_cells};

	always @* begin
		case (reg_addr)
		`FASB_ADDR_SAFETY_ALERT_ONE: rd_mux = safety_alert_one;
		`FASB_ADDR_CELL_ALERT_SUMMARY: rd_mux = cell_word;
		`FASB_ADDR_OVERVOLTAGE_ALERTS: rd_mux = ov_word;
		default: rd_mux = 16'h0000;
		endcase
	end

	// Read data and status summaries, all from flip-flops.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
			reg_rvalid <= 1'b0;
			safety_alert_any <= 1'b0;
			overvolt_any <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
				reg_rdata <= rd_mux;
			safety_alert_any <= |safety_alert_one;
			overvolt_any <= |ov_word;
		end
	end

endmodule // fasb_bank

module fasb_alert_latch (
	// Clock and reset.
	input wire clk,
	input wire rst_n,
	// Set request and host write.
	input wire set,
	input wire wr_en,
	input wire wdata,
	// Latched alert.
	output reg q
);

	// A set in the same cycle as a zero write wins over the clear.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			q <= 1'b0;
		else if (set)
			q <= 1'b1;
		else if (wr_en && !wdata)
			q <= 1'b0;
	end

endmodule // fasb_alert_latch

// ---- testbench/fasb_bank_sva.sv ----
// Port checks on the alert bank.
`timescale 1ns/1ps
module fasb_bank_sva #(
	parameter NCELL = 12,
	parameter OSC_UPDATE_CYC = 6
) (
	// Clock, reset and register port.
	input wire clk,
	input wire arst_n,
	input wire [7:0] reg_addr,
	input wire reg_rd,
	input wire [15:0] reg_rdata,
	input wire reg_rvalid,
	// Sources.
	input wire power_on_alert,
	input wire upper_rx_single_ended,
	input wire hv_supply_undervolt,
	input wire die_overtemp,
	input wire [NCELL-1:0] balance_switch_fault,
	input wire acq_done,
	input wire [NCELL-1:0] cell_over_cmp,
	input wire [NCELL-1:0] overvolt_alert_enable,
	input wire [1:0] aux_cold_cmp,
	// Summaries.
	input wire safety_alert_any,
	input wire overvolt_any
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	unmapped_zero_a: assert property (reg_rd && reg_addr > 8'h05 |=>
		reg_rvalid && reg_rdata == 16'h0000) else $error("unmapped read");
	bit13_zero_a: assert property (reg_rd && reg_addr == 8'h03 |=>
		!reg_rdata[13]) else $error("bit 13 set");
	temp_any_a: assert property (die_overtemp |-> ##2 safety_alert_any)
		else $error("overtemp lost");
	balsw_any_a: assert property (|balance_switch_fault |-> ##2
		safety_alert_any) else $error("balance lost");
	se_copy_a: assert property (upper_rx_single_ended |-> ##2
		safety_alert_any) else $error("copy lost");
	hv_set_a: assert property (hv_supply_undervolt && !power_on_alert
		|-> ##2 safety_alert_any) else $error("hv lost");
	ov_set_a: assert property (acq_done && |(cell_over_cmp &
		overvolt_alert_enable) |-> ##2 overvolt_any) else $error("ov lost");
	ov_off_a: assert property (acq_done && !(|(cell_over_cmp &
		overvolt_alert_enable)) && !(|aux_cold_cmp) |-> ##2 !overvolt_any)
		else $error("ov odd");
	cover property (acq_done);
	cover property (reg_rd && reg_addr == 8'h03);
	cover property (power_on_alert ##1 !power_on_alert);
endmodule // fasb_bank_sva
bind fasb_bank fasb_bank_sva #(.NCELL(NCELL),
	.OSC_UPDATE_CYC(OSC_UPDATE_CYC)) chk_i (.clk, .arst_n, .reg_addr,
	.reg_rd, .reg_rdata, .reg_rvalid, .power_on_alert,
	.upper_rx_single_ended, .hv_supply_undervolt, .die_overtemp,
	.balance_switch_fault, .acq_done, .cell_over_cmp,
	.overvolt_alert_enable, .aux_cold_cmp, .safety_alert_any, .overvolt_any);

// ---- testbench/fasb_host.sv ----
// Host model driving the register port.
`timescale 1ns/1ps
module fasb_host (
	input wire clk,
	output reg [7:0] reg_addr,
	output reg reg_wr,
	output reg reg_rd,
	output reg [15:0] reg_wdata,
	input wire [15:0] reg_rdata,
	input wire reg_rvalid
);
	initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 0;
	task wr(input [7:0] a, input [15:0] d); begin
		@(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {~a, ~d, 1'b0};
	end endtask
	task rd(input [7:0] a, output [15:0] d); begin
		@(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk) {reg_addr, reg_rd} <= {~a, 1'b0};
		#1 d = reg_rvalid ? reg_rdata : 16'hxxxx;
	end endtask
endmodule // fasb_host

// ---- testbench/fasb_bank_test.sv ----
// Self-checking test of the alert bank.
`timescale 1ns/1ps
module fasb_bank_test;
	reg clk, arst_n, power_on_alert, osc_freq_err, upper_rx_single_ended;
	reg lower_rx_single_ended, hv_supply_undervolt, die_overtemp;
	reg diag_settle_short, acq_done;
	reg [2:0] ldo_undervolt, gnd_open;
	reg [11:0] balance_switch_fault, cell_over_cmp, overvolt_alert_enable;
	reg [11:0] cell_undervolt;
	reg [1:0] aux_cold_cmp, aux_hot;
	wire [7:0] reg_addr;
	wire reg_wr, reg_rd, reg_rvalid, safety_alert_any, overvolt_any;
	wire [15:0] reg_wdata, reg_rdata;
	integer miscompares = 0, tests_run = 0, i;
	reg [15:0] v;
	fasb_host host (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.reg_rdata, .reg_rvalid);
	fasb_bank #(.OSC_UPDATE_CYC(6)) dut (.clk, .arst_n, .reg_addr, .reg_wr,
		.reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .power_on_alert,
		.osc_freq_err, .upper_rx_single_ended, .lower_rx_single_ended,
		.ldo_undervolt, .gnd_open, .hv_supply_undervolt, .die_overtemp,
		.diag_settle_short, .balance_switch_fault, .acq_done, .cell_over_cmp,
		.overvolt_alert_enable, .cell_undervolt, .aux_cold_cmp, .aux_hot,
		.safety_alert_any, .overvolt_any);
	task chk(input [15:0] got, input [15:0] exp); begin
		tests_run = tests_run + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	end endtask
	task rc(input [7:0] a, input [15:0] e); begin
		host.rd(a, v);
		chk(v, e);
		@(posedge clk);
	end endtask
	task acquire(input [11:0] c, input [11:0] e, input [1:0] a); begin
		{cell_over_cmp, overvolt_alert_enable, aux_cold_cmp} <= {c, e, a};
		acq_done <= 1;
		@(posedge clk) acq_done <= 0;
		repeat (2) @(posedge clk);
	end endtask
	task stop_test; begin
		if (miscompares == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	end endtask
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	initial begin
		#100000 miscompares = miscompares + 1;
		stop_test;
	end
	initial begin
		{osc_freq_err, upper_rx_single_ended, lower_rx_single_ended} = 0;
		{hv_supply_undervolt, die_overtemp, diag_settle_short, acq_done} = 0;
		{ldo_undervolt, gnd_open, balance_switch_fault, cell_over_cmp} = 0;
		{overvolt_alert_enable, cell_undervolt, aux_cold_cmp, aux_hot} = 0;
		power_on_alert = 1;
		arst_n = 0;
		repeat (2) @(posedge clk);
		arst_n <= 1;
		repeat (4) @(posedge clk);
		for (i = 3; i < 6; i = i + 1) rc(i[7:0], 16'h0000);
		{upper_rx_single_ended, lower_rx_single_ended} <= 2'b11;
		{gnd_open, ldo_undervolt, hv_supply_undervolt} <= 7'h7f;
		repeat (2) @(posedge clk);
		{gnd_open, ldo_undervolt, hv_supply_undervolt} <= 0;
		rc(8'h03, 16'h0600);
		power_on_alert <= 0;
		{gnd_open, ldo_undervolt, hv_supply_undervolt, die_overtemp} <= 8'hff;
		repeat (2) @(posedge clk);
		{gnd_open, ldo_undervolt, hv_supply_undervolt, die_overtemp} <= 0;
		rc(8'h03, 16'h1fdf);
		chk(safety_alert_any, 16'h0001);
		host.wr(8'h03, 16'hffff);
		rc(8'h03, 16'h1fdf);
		host.wr(8'h03, 16'h0000);
		rc(8'h03, 16'h1e00);
		balance_switch_fault <= 12'h008;
		host.wr(8'h03, 16'h0000);
		rc(8'h03, 16'h1e20);
		balance_switch_fault <= 0;
		repeat (2) @(posedge clk);
		rc(8'h03, 16'h1e00);
		{osc_freq_err, diag_settle_short} <= 2'b11;
		repeat (8) @(posedge clk);
		{osc_freq_err, diag_settle_short} <= 0;
		rc(8'h03, 16'hde10);
		host.wr(8'h03, 16'h4000);
		rc(8'h03, 16'h5e00);
		acquire(12'h001, 12'h001, 2'b00);
		rc(8'h05, 16'h0001);
		chk(overvolt_any, 16'h0001);
		acquire(12'h001, 12'h000, 2'b00);
		rc(8'h05, 16'h0000);
		{aux_hot, cell_undervolt} <= {2'b01, 12'h002};
		acquire(12'h000, 12'h000, 2'b10);
		rc(8'h05, 16'h2000);
		rc(8'h04, 16'h3002);
		host.wr(8'h05, 16'hffff);
		rc(8'h05, 16'h2000);
		acquire(12'h000, 12'h000, 2'b00);
		rc(8'h05, 16'h0000);
		rc(8'h10, 16'h0000);
		stop_test;
	end
endmodule // fasb_bank_test
